// >>> common/ridc_defines.svh
`ifndef RIDC_DEFINES_SVH
`define RIDC_DEFINES_SVH
`define RIDC_OFS_A_DIV_HIGH 8'h1F
`define RIDC_OFS_A_DIV_LOW 8'h20
`define RIDC_OFS_A_PRESCALE 8'h21
`define RIDC_OFS_A_SPARE 8'h22
`define RIDC_OFS_B_DIV_HIGH 8'h23
`define RIDC_OFS_B_DIV_LOW 8'h24
`define RIDC_OFS_B_PRESCALE 8'h25
`define RIDC_OFS_B_SPARE 8'h26
`define RIDC_LOW_DIV_MSB 7
`define RIDC_LOW_DIV_LSB 2
`define RIDC_LOW_OVR_BIT 1
`define RIDC_DBL_OVR_BIT 7
`define RIDC_DBL_SEL_BIT 6
`define RIDC_PS5_OVR_BIT 5
`define RIDC_PS5_SEL_BIT 4
`define RIDC_A_DIV_RESET 14'h1000
`define RIDC_B_DIV_RESET 14'h2000
`define RIDC_LOW_MASK 8'hFE
`define RIDC_PRESCALE_MASK 8'hF0
`endif

// >>> common/ridc_pkg.sv
package ridc_pkg;
    typedef logic [7:0] ridc_byte_t;
    typedef logic [13:0] ridc_div_t;
endpackage : ridc_pkg

// >>> hw/ridc_ref_path.sv
`include "ridc_defines.svh"

// One reference input's divider, doubler and prescaler registers.
module ridc_ref_path #(
    parameter logic [7:0] OFS_HIGH = 8'h1F,
    parameter ridc_pkg::ridc_div_t DIV_RESET = 14'h1000
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Register write port.
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire ridc_pkg::ridc_byte_t wr_data,
    // Register read views.
    output ridc_pkg::ridc_byte_t high_q,
    output ridc_pkg::ridc_byte_t low_q,
    output ridc_pkg::ridc_byte_t pre_q,
    // Values from the strapping pin decode.
    input wire ridc_pkg::ridc_div_t strap_div,
    input wire logic strap_dbl,
    input wire logic strap_ps5,
    // Effective settings.
    output ridc_pkg::ridc_div_t div_eff,
    output logic dbl_eff,
    output logic ps5_eff
);
    localparam logic [7:0] OFS_LOW = OFS_HIGH + 8'h01;
    localparam logic [7:0] OFS_PRE = OFS_HIGH + 8'h02;
    localparam ridc_pkg::ridc_byte_t LOW_RST =
        {DIV_RESET[5:0], 2'b00};

    ridc_pkg::ridc_byte_t high_r;
    ridc_pkg::ridc_byte_t low_r;
    ridc_pkg::ridc_byte_t pre_r;

    wire logic hit_high = wr_en && (wr_addr == OFS_HIGH);
    wire logic hit_low = wr_en && (wr_addr == OFS_LOW);
    wire logic hit_pre = wr_en && (wr_addr == OFS_PRE);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            high_r <= DIV_RESET[13:6];
            low_r <= LOW_RST;
            pre_r <= 8'h00;
        end else begin
            if (hit_high) begin
                high_r <= wr_data;
            end
            if (hit_low) begin
                low_r <= wr_data & `RIDC_LOW_MASK;
            end
            if (hit_pre) begin
                pre_r <= wr_data & `RIDC_PRESCALE_MASK;
            end
        end
    end

    assign high_q = high_r;
    assign low_q = low_r;
    assign pre_q = pre_r;

    wire ridc_pkg::ridc_div_t reg_div =
        {high_r, low_r[`RIDC_LOW_DIV_MSB:`RIDC_LOW_DIV_LSB]};
    assign div_eff = low_r[`RIDC_LOW_OVR_BIT] ? reg_div : strap_div;
    assign dbl_eff = pre_r[`RIDC_DBL_OVR_BIT] ?
        pre_r[`RIDC_DBL_SEL_BIT] : strap_dbl;
    assign ps5_eff = pre_r[`RIDC_PS5_OVR_BIT] ?
        pre_r[`RIDC_PS5_SEL_BIT] : strap_ps5;
endmodule : ridc_ref_path

// >>> hw/ridc_regs.sv
`include "ridc_defines.svh"

// Summary of operation
// RL1 - 0x1F holds first divider bits 13..6.
// RL2 - 0x20[7:2] low bits; divider resets 4096.
// RL3 - 0x20[1] picks register over strap divider.
// RL4 - ref_a_prescale_ctrl[7] enables register doubler control.
// RL5 - ref_a_prescale_ctrl[6] engages first doubler when enabled.
// RL6 - ref_a_prescale_ctrl[5] enables register prescaler control.
// RL7 - ref_a_prescale_ctrl[4] engages first prescaler when enabled.
// RL8 - 0x23 holds second divider bits 13..6.
// RL9 - 0x24[7:2] low bits; divider resets 8192.
// RL10 - 0x24[1] picks register over strap divider.
// RL11 - ref_b_prescale_ctrl[7] enables register doubler control.
// RL12 - ref_b_prescale_ctrl[6] engages second doubler when enabled.
// RL13 - ref_b_prescale_ctrl[5] enables register prescaler control.
// RL14 - ref_b_prescale_ctrl[4] engages second prescaler when enabled.
// RL15 - Unused bits ignore writes, read zero.
// RL16 - Host writes divider halves before override.
module ridc_regs (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Register access from the serial port logic.
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire ridc_pkg::ridc_byte_t wr_data,
    output ridc_pkg::ridc_byte_t rd_data,
    // Strapping pin decode for the first input.
    input wire ridc_pkg::ridc_div_t strap_a_div,
    input wire logic strap_a_dbl,
    input wire logic strap_a_ps5,
    // Strapping pin decode for the second input.
    input wire ridc_pkg::ridc_div_t strap_b_div,
    input wire logic strap_b_dbl,
    input wire logic strap_b_ps5,
    // Effective first input settings.
    output ridc_pkg::ridc_div_t first_input_divider,
    output logic first_input_doubler,
    output logic first_input_div5_prescaler,
    // Effective second input settings.
    output ridc_pkg::ridc_div_t second_input_divider,
    output logic second_input_doubler,
    output logic second_input_div5_prescaler
);
    ridc_pkg::ridc_byte_t a_high;
    ridc_pkg::ridc_byte_t a_low;
    ridc_pkg::ridc_byte_t a_pre;
    ridc_pkg::ridc_byte_t b_high;
    ridc_pkg::ridc_byte_t b_low;
    ridc_pkg::ridc_byte_t b_pre;
    ridc_pkg::ridc_byte_t rd_nxt;
    ridc_pkg::ridc_byte_t rd_data_r;

    // The strapping decode comes from pins, so it passes three stages.
    // A bit is taken over only once the second and third stages agree.
    logic [31:0] pin_raw;
    logic [31:0] pin_s1_r;
    logic [31:0] pin_s2_r;
    logic [31:0] pin_s3_r;
    logic [31:0] pin_q_r;
    logic [31:0] pin_agree;
    logic [31:0] pin_q_nxt;

    assign pin_raw = {strap_a_div, strap_a_dbl, strap_a_ps5,
        strap_b_div, strap_b_dbl, strap_b_ps5};
    assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
    assign pin_q_nxt = (pin_s3_r & pin_agree) | (pin_q_r & ~pin_agree);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 32'h0000_0000;
            pin_s2_r <= 32'h0000_0000;
            pin_s3_r <= 32'h0000_0000;
            pin_q_r <= 32'h0000_0000;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_q_r <= pin_q_nxt;
        end
    end

    wire ridc_pkg::ridc_div_t sync_a_div = pin_q_r[31:18];
    wire logic sync_a_dbl = pin_q_r[17];
    wire logic sync_a_ps5 = pin_q_r[16];
    wire ridc_pkg::ridc_div_t sync_b_div = pin_q_r[15:2];
    wire logic sync_b_dbl = pin_q_r[1];
    wire logic sync_b_ps5 = pin_q_r[0];

    // First input path: registers 0x1F to ref_a_prescale_ctrl.
    ridc_ref_path #(
        .OFS_HIGH(`RIDC_OFS_A_DIV_HIGH),
        .DIV_RESET(`RIDC_A_DIV_RESET) // RL2
    ) u_path_a (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_en), // RL1
        .wr_addr(addr),
        .wr_data(wr_data),
        .high_q(a_high),
        .low_q(a_low),
        .pre_q(a_pre),
        .strap_div(sync_a_div), // RL3
        .strap_dbl(sync_a_dbl), // RL4
        .strap_ps5(sync_a_ps5), // RL6
        .div_eff(first_input_divider),
        .dbl_eff(first_input_doubler), // RL5
        .ps5_eff(first_input_div5_prescaler) // RL7
    );

    // Second input path: registers 0x23 to ref_b_prescale_ctrl.
    ridc_ref_path #(
        .OFS_HIGH(`RIDC_OFS_B_DIV_HIGH),
        .DIV_RESET(`RIDC_B_DIV_RESET) // RL9
    ) u_path_b (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_en), // RL8
        .wr_addr(addr),
        .wr_data(wr_data),
        .high_q(b_high),
        .low_q(b_low),
        .pre_q(b_pre),
        .strap_div(sync_b_div), // RL10
        .strap_dbl(sync_b_dbl), // RL11
        .strap_ps5(sync_b_ps5), // RL13
        .div_eff(second_input_divider),
        .dbl_eff(second_input_doubler), // RL12
        .ps5_eff(second_input_div5_prescaler) // RL14
    );

    // Spare registers and unmapped addresses read as zero.
    always_comb begin
        case (addr)
            `RIDC_OFS_A_DIV_HIGH: rd_nxt = a_high;
            `RIDC_OFS_A_DIV_LOW: rd_nxt = a_low;
            `RIDC_OFS_A_PRESCALE: rd_nxt = a_pre;
            `RIDC_OFS_B_DIV_HIGH: rd_nxt = b_high;
            `RIDC_OFS_B_DIV_LOW: rd_nxt = b_low;
            `RIDC_OFS_B_PRESCALE: rd_nxt = b_pre;
            default: rd_nxt = 8'h00; // RL15
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_nxt;
        end
    end

    assign rd_data = rd_data_r;
endmodule : ridc_regs

// >>> test/ridc_chk_properties.sv
module ridc_chk (
    input logic mclk, rst_n, wr_en, strap_a_dbl, first_input_doubler,
    input logic [7:0] addr, wr_data, rd_data,
    input logic [13:0] strap_a_div, first_input_divider
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lw;
    logic [7:0] la, ld;
    wire rb = lw && !wr_en && la == addr;
    always_ff @(posedge mclk) begin
        {lw, la, ld} <= {wr_en, addr, wr_data};
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    hi_rd_a: assert property (rb && addr == 8'h1F
        |=> rd_data == $past(ld)) else $error("hi rd");
    lo_rd_a: assert property (rb && addr == 8'h20
        |=> rd_data == ($past(ld) & 8'hFE)) else $error("lo rd");
    ps_rd_a: assert property (rb && addr == 8'h21
        |=> rd_data == ($past(ld) & 8'hF0)) else $error("ps rd");
    b_hi_a: assert property (rb && addr == 8'h23
        |=> rd_data == $past(ld)) else $error("b hi rd");
    b_lo_a: assert property (rb && addr == 8'h24
        |=> rd_data == ($past(ld) & 8'hFE)) else $error("b lo rd");
    spare_rd_a: assert property (addr == 8'h22 || addr == 8'h26
        |=> rd_data == 8'h00) else $error("spare rd");
    a_strap_a: assert property (wr_en && addr == 8'h20 && !wr_data[1]
        |=> first_input_divider == strap_a_div) else $error("a div");
    a_dbl_a: assert property (wr_en && addr == 8'h21 |=>
        first_input_doubler == ($past(wr_data[7]) ? $past(wr_data[6])
        : strap_a_dbl)) else $error("a dbl");
endmodule : ridc_chk

// >>> test/ridc_host.sv
module ridc_host (
    input logic mclk,
    output logic wr_en = 1'h0,
    output logic [7:0] addr = 8'h00, wr_data = 8'h00,
    input logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    task wr(input logic [7:0] a, v);
        {wr_en, addr, wr_data} = {1'h1, a, v};
        @(negedge mclk);
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] v);
        {wr_en, addr} = {1'h0, a};
        @(negedge mclk);
        v = rd_data;
    endtask : rd
endmodule : ridc_host

// >>> test/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, rst_n = 1'h0, wr_en;
    logic strap_a_dbl = 1'h0, strap_a_ps5 = 1'h1;
    logic strap_b_dbl = 1'h1, strap_b_ps5 = 1'h0;
    logic first_input_doubler, first_input_div5_prescaler;
    logic second_input_doubler, second_input_div5_prescaler;
    logic [7:0] addr, wr_data, rd_data, d;
    logic [7:0] m[4] = '{8'hFF, 8'hFE, 8'hF0, 8'h00};
    logic [13:0] strap_a_div = 14'h0123, strap_b_div = 14'h0456;
    logic [13:0] first_input_divider, second_input_divider;
    wire [3:0] fx = {first_input_doubler, first_input_div5_prescaler,
        second_input_doubler, second_input_div5_prescaler};
    int errors = 0, compares = 0;
    ridc_host u_host (.*);
    ridc_regs u_dut (.*);
    task chk(string n, logic [13:0] s, e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task conclude;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    initial forever #12.5 mclk = ~mclk;
    initial begin
        repeat (2) @(negedge mclk);
        rst_n = 1'h1;
        repeat (4) @(negedge mclk);
        chk("da", first_input_divider, strap_a_div);
        chk("db", second_input_divider, strap_b_div);
        chk("fx", fx, 4'h6);
        for (int i = 0; i < 8; i++) begin
            u_host.rd(8'h1F + i[7:0], d);
            chk("rst", d, {i == 4, i == 0, 6'h00});
        end
        for (int i = 0; i < 8; i++) begin
            u_host.wr(8'h1F + i[7:0], 8'hFF);
            u_host.rd(8'h1F + i[7:0], d);
            chk("rb", d, m[i % 4]);
        end
        chk("da", first_input_divider, 14'h3FFF);
        chk("db", second_input_divider, 14'h3FFF);
        chk("fx", fx, 4'hF);
        u_host.wr(8'h1F, 8'h00);
        u_host.wr(8'h20, 8'h06);
        chk("da", first_input_divider, 14'h0001);
        u_host.wr(8'h20, 8'hA5);
        u_host.wr(8'h21, 8'hA0);
        u_host.wr(8'h25, 8'h50);
        strap_b_ps5 = 1'h1;
        repeat (4) @(negedge mclk);
        u_host.rd(8'h24, d);
        chk("da", first_input_divider, strap_a_div);
        chk("fx", fx, 4'h3);
        conclude();
    end
endmodule : tb
bind ridc_regs ridc_chk u_chk (.*);
